/* mrpcs_pkg.sv */
package mrpcs_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] LOW_SEL_IDX = 8'hA2;
  localparam logic [7:0] PERI_SEL_IDX = 8'hA4;
  localparam logic [7:0] MID_BASE_IDX = 8'hA6;
  localparam logic [7:0] AUX_IDX = 8'hA8;
  localparam logic [11:0] LOW_SEL_ADDR = {2'h0, LOW_SEL_IDX, 2'h0};
  localparam logic [11:0] PERI_SEL_ADDR = {2'h0, PERI_SEL_IDX, 2'h0};
  localparam logic [11:0] MID_BASE_ADDR = {2'h0, MID_BASE_IDX, 2'h0};
  localparam logic [11:0] AUX_ADDR = {2'h0, AUX_IDX, 2'h0};

  localparam logic [15:0] CFG_RST = 16'h0000;

  // Field positions
  localparam int MID_BASE_LSB = 9;
  localparam int PERI_BASE_LSB = 7;
  localparam int SIZE_LSB = 8;
  localparam int SIZE_W = 7;
  localparam int PIN_SEL_BIT = 7;
  localparam int SPACE_SEL_BIT = 6;
  localparam int WAIT_HI_BIT = 3;
  localparam int READY_MODE_BIT = 2;
  localparam int ADDR_DIS_BIT = 7;

  // Bus address layout
  localparam int MID_ADDR_LSB = 13;
  localparam int PERI_ADDR_LSB = 11;
  localparam int PERI_SLOT_LSB = 8;
  localparam logic [4:0] MID_QUARTER_SHIFT = 5'h0B;
  localparam logic [2:0] SEL5_SLOT = 3'h5;
  localparam logic [2:0] SEL6_SLOT = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_READY = 3'b100
  } mrpcs_state_t;

endpackage

/* mrpcs_top.sv */
// Operation
// - One-hot size code splits block in four
// - Pin selector: upper selects or latched a1/a2
// - Space selector gates peripheral selects by cycle
// - Aux ready and waits apply to selects 5,6
// - Midrange base gives address bits 19..13
// - Midrange selects active after both writes
// - Midrange selects use later multiplexed bus timing; here they are registered on the same edge as the peripheral selects
// - I/O peripheral selects may overlap midrange
// - Midrange ready mode and 0-3 waits
// - Peripheral base gives address bits 19..11
// - 256-byte peripheral ranges, five at 1280, six 1536
// - Peripheral block in memory or I/O space
// - Lower peripheral waits 0,1,2,3,5,7,9,15
// - Peripheral pins active after both writes
// - Low select active once the low select register is written
// - Reset clears the address disable bit
module mrpcs_top
  import mrpcs_pkg::*;
#(
  parameter int PAW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycleStart,
  input wire logic cycleIsMem,
  input wire logic [19:0] cycleAddr,
  input wire logic extReady,
  output logic cycleDone,
  output logic [3:0] midrangeSelectPinsN,
  output logic [3:0] lowerPeripheralSelectPinsN,
  output logic [1:0] upperPeripheralSelectPinsN,
  output logic lowSelectActive,
  output logic addressDriveDisable
);

  logic [15:0] lowSelCfg_r;
  logic [15:0] periSelCfg_r;
  logic [15:0] midBaseCfg_r;
  logic [15:0] auxCfg_r;
  logic midWritten_r;
  logic periWritten_r;
  logic auxWritten_r;
  logic lowActive_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  mrpcs_state_t state_r;
  logic [3:0] waitCnt_r;
  logic ignoreReady_r;
  logic [3:0] midSel_r;
  logic [3:0] lowerSel_r;
  logic [1:0] upperSel_r;
  logic [1:0] addrLatch_r;

  // ---------------- APB slave ----------------
  logic setupPh;
  logic wrStrobe;
  logic hitLow;
  logic hitPeri;
  logic hitMid;
  logic hitAux;
  logic mapped;
  logic [15:0] readMux;

  assign setupPh = psel & ~penable;
  assign pready = psel & penable;
  assign wrStrobe = psel & penable & pwrite;
  assign hitLow = paddr == PAW'(LOW_SEL_ADDR);
  assign hitPeri = paddr == PAW'(PERI_SEL_ADDR);
  assign hitMid = paddr == PAW'(MID_BASE_ADDR);
  assign hitAux = paddr == PAW'(AUX_ADDR);
  assign mapped = hitLow | hitPeri | hitMid | hitAux;

  always_comb begin
    readMux = 16'h0000;
    if (hitLow) begin
      readMux = lowSelCfg_r;
    end else if (hitPeri) begin
      readMux = periSelCfg_r;
    end else if (hitMid) begin
      readMux = midBaseCfg_r;
    end else if (hitAux) begin
      readMux = auxCfg_r;
    end
  end

  // Read data and error are captured in the setup cycle so they come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setupPh) begin
      prdata_r <= {16'h0000, readMux};
      pslverr_r <= ~mapped;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Contents are undefined after reset in hardware; zero keeps simulation clean
  always_ff @(posedge clk) begin
    if (rst) begin
      lowSelCfg_r <= CFG_RST;
      periSelCfg_r <= CFG_RST;
      midBaseCfg_r <= CFG_RST;
      auxCfg_r <= CFG_RST;
    end else if (wrStrobe) begin
      if (hitLow) begin
        lowSelCfg_r <= pwdata[15:0];
      end
      if (hitPeri) begin
        periSelCfg_r <= pwdata[15:0];
      end
      if (hitMid) begin
        midBaseCfg_r <= pwdata[15:0];
      end
      if (hitAux) begin
        auxCfg_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      midWritten_r <= 1'b0;
      periWritten_r <= 1'b0;
      auxWritten_r <= 1'b0;
      lowActive_r <= 1'b0;
    end else if (wrStrobe) begin
      midWritten_r <= midWritten_r | hitMid;
      periWritten_r <= periWritten_r | hitPeri;
      auxWritten_r <= auxWritten_r | hitAux;
      lowActive_r <= lowActive_r | hitLow;
    end
  end

  assign lowSelectActive = lowActive_r;
  assign addressDriveDisable = lowSelCfg_r[ADDR_DIS_BIT];

  logic midEnable;
  logic pcsEnable;
  logic pinSelector;
  logic spaceSelector;

  assign midEnable = midWritten_r & auxWritten_r;
  assign pcsEnable = periWritten_r & auxWritten_r;
  assign pinSelector = auxCfg_r[PIN_SEL_BIT];
  assign spaceSelector = auxCfg_r[SPACE_SEL_BIT];

  // ---------------- Address decode ----------------
  function automatic logic [2:0] sizePos(input logic [SIZE_W-1:0] code);
    logic [2:0] pos;
    pos = 3'h0;
    for (int i = 0; i < SIZE_W; i++) begin
      if (code[i]) begin
        pos = 3'(i);
      end
    end
    return pos;
  endfunction

  function automatic logic [3:0] periWaits(input logic [2:0] code);
    logic [3:0] w;
    unique case (code)
      3'h0: w = 4'h0;
      3'h1: w = 4'h1;
      3'h2: w = 4'h2;
      3'h3: w = 4'h3;
      3'h4: w = 4'h5;
      3'h5: w = 4'h7;
      3'h6: w = 4'h9;
      3'h7: w = 4'hF;
    endcase
    return w;
  endfunction

  logic [SIZE_W-1:0] sizeCode;
  logic [SIZE_W-1:0] lowMask;
  logic sizeLegal;
  logic [6:0] midBase;
  logic [4:0] quarterShift;
  logic [19:0] shiftedAddr;
  logic [1:0] midIdx;
  logic midHit;

  assign sizeCode = auxCfg_r[SIZE_LSB +: SIZE_W];
  assign sizeLegal = $onehot(sizeCode);
  assign lowMask = sizeCode - 7'h01;
  assign quarterShift = MID_QUARTER_SHIFT + 5'(sizePos(sizeCode));
  assign shiftedAddr = cycleAddr >> quarterShift;
  assign midIdx = shiftedAddr[1:0];
  // base bits 19..13, low bits zero; an illegal size code selects nothing
  assign midBase = midBaseCfg_r[MID_BASE_LSB +: 7];
  assign midHit = midEnable & cycleIsMem & sizeLegal &
                  ((cycleAddr[19:MID_ADDR_LSB] & ~lowMask) == (midBase & ~lowMask));

  logic [19:0] effAddr;
  logic spaceOk;
  logic periHit;
  logic [2:0] slot;
  logic lowerHit;
  logic upperHit;

  // I/O cycles carry 16 bits, upper address treated as zero
  assign effAddr = cycleIsMem ? cycleAddr : {4'h0, cycleAddr[15:0]};
  assign spaceOk = spaceSelector == cycleIsMem;
  assign periHit = pcsEnable & spaceOk &
                   (effAddr[19:PERI_ADDR_LSB] == periSelCfg_r[15:PERI_BASE_LSB]);
  // 256-byte slots; slot four and seven are unused
  assign slot = effAddr[PERI_ADDR_LSB-1:PERI_SLOT_LSB];
  assign lowerHit = periHit & ~slot[2];
  assign upperHit = periHit & pinSelector & ((slot == SEL5_SLOT) | (slot == SEL6_SLOT));

  // midrange wins; in I/O space the two never meet
  logic anyHit;
  logic [3:0] nextWaits;
  logic nextIgnore;

  always_comb begin
    nextWaits = 4'h0;
    nextIgnore = 1'b1;
    if (midHit) begin
      nextWaits = {2'h0, midBaseCfg_r[1:0]};
      nextIgnore = midBaseCfg_r[READY_MODE_BIT];
    end else if (lowerHit) begin
      nextWaits = periWaits({periSelCfg_r[WAIT_HI_BIT], periSelCfg_r[1:0]});
      nextIgnore = periSelCfg_r[READY_MODE_BIT];
    end else if (upperHit) begin
      // auxiliary ready and waits for selects 5 and 6
      nextWaits = {2'h0, auxCfg_r[1:0]};
      nextIgnore = auxCfg_r[READY_MODE_BIT];
    end
  end

  assign anyHit = midHit | lowerHit | upperHit;

  // ---------------- Cycle sequencer ----------------
  logic takeCycle;
  logic waitDone;

  assign takeCycle = (state_r == ST_IDLE) & cycleStart & anyHit;
  // waits first, then sampled ready unless ignored
  assign waitDone = ((state_r == ST_WAIT) & (waitCnt_r == 4'h0) & (ignoreReady_r | extReady)) |
                    ((state_r == ST_READY) & extReady);
  assign cycleDone = waitDone;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      waitCnt_r <= 4'h0;
      ignoreReady_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (takeCycle) begin
            state_r <= ST_WAIT;
            waitCnt_r <= nextWaits;
            ignoreReady_r <= nextIgnore;
          end
        end
        ST_WAIT: begin
          if (waitCnt_r != 4'h0) begin
            waitCnt_r <= waitCnt_r - 4'h1;
          end else if (ignoreReady_r | extReady) begin
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_READY;
          end
        end
        ST_READY: begin
          if (extReady) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // selects registered: one cycle after the address phase they were decoded in
  always_ff @(posedge clk) begin
    if (rst) begin
      midSel_r <= 4'h0;
      lowerSel_r <= 4'h0;
      upperSel_r <= 2'h0;
    end else if (takeCycle) begin
      midSel_r <= midHit ? (4'h1 << midIdx) : 4'h0;
      lowerSel_r <= (!midHit && lowerHit) ? (4'h1 << slot[1:0]) : 4'h0;
      upperSel_r <= (!midHit && upperHit) ? {slot == SEL6_SLOT, slot == SEL5_SLOT} : 2'h0;
    end else if (waitDone) begin
      midSel_r <= 4'h0;
      lowerSel_r <= 4'h0;
      upperSel_r <= 2'h0;
    end
  end

  // Latched a2/a1 follow every address phase, decoded or not
  always_ff @(posedge clk) begin
    if (rst) begin
      addrLatch_r <= 2'h0;
    end else if (cycleStart) begin
      addrLatch_r <= cycleAddr[2:1];
    end
  end

  assign midrangeSelectPinsN = ~midSel_r;
  assign lowerPeripheralSelectPinsN = ~lowerSel_r;
  // upper pins as selects or latched address
  assign upperPeripheralSelectPinsN = (pcsEnable & ~pinSelector) ? addrLatch_r : ~upperSel_r;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start_mid_fast;
    takeCycle & midHit & nextIgnore & (nextWaits == 4'h0);
  endsequence

  sequence s_start_lower_slow;
    takeCycle & !midHit & lowerHit & nextIgnore & (nextWaits == 4'hF);
  endsequence

  sequence s_start_upper_three;
    takeCycle & !midHit & upperHit & nextIgnore & (nextWaits == 4'h3);
  endsequence

  a_mid_stays_off: assert property (!midEnable |-> midrangeSelectPinsN == 4'hF)
    else $error("midrange select active before both writes");

  a_peri_stays_off: assert property (!pcsEnable |->
      lowerPeripheralSelectPinsN == 4'hF && upperPeripheralSelectPinsN == 2'h3)
    else $error("peripheral pin active before both writes");

  a_mid_quarter_sel: assert property (takeCycle & midHit |=>
      midrangeSelectPinsN == ~(4'h1 << $past(midIdx)))
    else $error("wrong midrange quarter selected");

  a_mid_zero_wait: assert property (s_start_mid_fast |=> cycleDone ##1 !cycleDone)
    else $error("midrange zero-wait cycle did not end next cycle");

  // Fifteen waits: done falls in the sixteenth cycle after the start
  a_lower_fifteen: assert property (s_start_lower_slow |=>
      !cycleDone[*8] ##1 !cycleDone[*7] ##1 cycleDone)
    else $error("fifteen wait states not honoured");

  a_upper_three: assert property (s_start_upper_three |-> ##4 cycleDone)
    else $error("select 5/6 wait states wrong");

  a_ready_needed: assert property (cycleDone & !ignoreReady_r |-> extReady)
    else $error("access ended without external ready");

  a_space_gate: assert property (cycleStart & (state_r == ST_IDLE) &
      (spaceSelector != cycleIsMem) |=> lowerPeripheralSelectPinsN == 4'hF)
    else $error("peripheral select in wrong space");

  a_io_no_mid: assert property (cycleStart & !cycleIsMem |=> midrangeSelectPinsN == 4'hF)
    else $error("midrange select on I/O cycle");

  a_addr_pins: assert property (cycleStart & pcsEnable & !pinSelector |=>
      upperPeripheralSelectPinsN == $past(cycleAddr[2:1]))
    else $error("latched address not on upper pins");

  a_low_activate: assert property (wrStrobe & hitLow |=> lowSelectActive)
    else $error("low select not activated by write");

  a_addr_dis_reset: assert property ($past(rst) |-> !addressDriveDisable)
    else $error("address disable not cleared by reset");

endmodule

/* mrpcs_bus_dev.sv */
module mrpcs_bus_dev (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] selN,
  input wire logic [3:0] readyDelay,
  output logic extReady
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] waitCnt_r;

  // Cycles that any select has been low; saturates so a stuck select stays ready
  always_ff @(posedge clk) begin
    if (rst || (&selN)) begin
      waitCnt_r <= 4'h0;
    end else if (waitCnt_r != 4'hF) begin
      waitCnt_r <= waitCnt_r + 4'h1;
    end
  end

  // shared pins taken as selects
  // Ready line has a board pull-down, so it reads low whenever nothing is selected
  assign extReady = !(&selN) && (waitCnt_r >= readyDelay);
endmodule

/* tb_top.sv */
module tb_top
  import mrpcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cycleStart, cycleIsMem, extReady, cycleDone, lowSelectActive, addressDriveDisable;
  logic [19:0] cycleAddr;
  logic [3:0] midN, lowerN, readyDelay;
  logic [1:0] upperN;
  logic [9:0] pins;
  int n_errors, checks, cycles;

  mrpcs_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycleStart(cycleStart), .cycleIsMem(cycleIsMem), .cycleAddr(cycleAddr),
    .extReady(extReady), .cycleDone(cycleDone), .midrangeSelectPinsN(midN),
    .lowerPeripheralSelectPinsN(lowerN), .upperPeripheralSelectPinsN(upperN),
    .lowSelectActive(lowSelectActive), .addressDriveDisable(addressDriveDisable));

  mrpcs_bus_dev partner (.clk(clk), .rst(rst), .selN({upperN, lowerN, midN}),
    .readyDelay(readyDelay), .extReady(extReady));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] rd, output logic err);
    int waits;
    waits = 0;
    // An idle edge first, so back-to-back calls never drive psel twice at one edge
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      waits++;
    end while (pready !== 1'b1);
    check(waits == 1, "pready latency");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
    check(r === x && e === xErr, "register read");
  endtask

  // Waits a fixed window long enough for 15 waits plus the slowest ready
  task automatic cyc(input logic mem, input logic [19:0] a, input int pin, input int lat);
    int got;
    got = -1;
    cycleStart <= 1'b1;
    cycleIsMem <= mem;
    cycleAddr <= a;
    @(posedge clk);
    cycleStart <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      #1;
      if (i == 0) pins = {upperN, lowerN, midN};
      if (cycleDone === 1'b1 && got < 0) got = i;
      @(posedge clk);
    end
    if (pin == -1) begin
      check(pins === 10'h3FF && got < 0, "unexpected select");
    end else if (pin >= 0) begin
      check(pins === ~(10'h001 << pin) && got == lat, "select or wait count");
    end
  endtask

  task automatic s_reset();
    check(lowSelectActive === 1'b0 && addressDriveDisable === 1'b0, "reset flags");
    check({upperN, lowerN, midN} === 10'h3FF, "reset pins");
    rdchk(LOW_SEL_ADDR, 32'h0, 1'b0);
    rdchk(12'h004, 32'h0, 1'b1);
    wr(LOW_SEL_ADDR, 16'h0FB8);
    rdchk(LOW_SEL_ADDR, 32'h00000FB8, 1'b0);
    check(lowSelectActive === 1'b1 && addressDriveDisable === 1'b1, "low select");
  endtask

  task automatic s_enable();
    wr(PERI_SEL_ADDR, 16'h4074);
    wr(MID_BASE_ADDR, 16'h21FE);
    cyc(1'b1, 20'h40000, -1, 0);
    cyc(1'b1, 20'h20000, -1, 0);
    wr(AUX_ADDR, 16'h84FD);
    rdchk(AUX_ADDR, 32'h000084FD, 1'b0);
    cyc(1'b1, 20'h40000, 4, 0);
  endtask

  task automatic s_mid();
    for (int q = 0; q < 4; q++) begin
      cyc(1'b1, 20'h21FFF + 20'(q) * 20'h02000, q, 2);
    end
    wr(MID_BASE_ADDR, 16'h21FC);
    cyc(1'b1, 20'h26000, 3, 0);
    cyc(1'b1, 20'h28000, -1, 0);
    cyc(1'b1, 20'h1FFFF, -1, 0);
    wr(MID_BASE_ADDR, 16'h21F9);
    readyDelay <= 4'h4;
    cyc(1'b1, 20'h20000, 0, 4);
    readyDelay <= 4'h0;
    cyc(1'b1, 20'h22000, 1, 1);
  endtask

  task automatic s_peri();
    int tbl[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    for (int c = 0; c < 8; c++) begin
      wr(PERI_SEL_ADDR, 16'h4074 | {12'h000, c[2], 1'b0, c[1:0]});
      cyc(1'b1, 20'h40000 + 20'(c % 4) * 20'h00100, 4 + c % 4, tbl[c]);
    end
    cyc(1'b1, 20'h40500, 8, 1);
    cyc(1'b1, 20'h406FF, 9, 1);
    wr(AUX_ADDR, 16'h84FF);
    cyc(1'b1, 20'h40500, 8, 3);
    wr(AUX_ADDR, 16'h84F8);
    readyDelay <= 4'h2;
    cyc(1'b1, 20'h40600, 9, 2);
    readyDelay <= 4'h0;
    cyc(1'b1, 20'h40400, -1, 0);
    cyc(1'b0, 20'h00000, -1, 0);
  endtask

  task automatic s_io();
    wr(PERI_SEL_ADDR, 16'h0074);
    wr(AUX_ADDR, 16'h84BD);
    cyc(1'b0, 20'h00100, 5, 0);
    cyc(1'b0, 20'h20000, 4, 0);
    cyc(1'b1, 20'h20000, 0, 1);
    cyc(1'b1, 20'h00100, -1, 0);
    wr(AUX_ADDR, 16'h847D);
    cyc(1'b1, 20'h00002, -2, 0);
    check(pins[9:8] === 2'b01, "latched a1");
    cyc(1'b1, 20'h00004, -2, 0);
    check(pins[9:8] === 2'b10, "latched a2");
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, cycleStart, cycleIsMem} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    cycleAddr = 20'h00000;
    readyDelay = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_enable();
    s_mid();
    s_peri();
    s_io();
    print_verdict();
  end
endmodule
